// ---- logic/host_port_pkg.sv ----
// constants, latency counts and state types for the host bus port
// assumes a single clock domain running at the internal controller clock
package host_port_pkg;
  localparam int         ADDR_W            = 8;
  localparam int         CLOCK_MHZ         = 200;
  localparam int         CLOCK_PERIOD_NS   = 1000 / CLOCK_MHZ;
  // register addresses answered without waiting on the write path, 02H in async mode only
  localparam logic [7:0] FAST_REG_A        = 8'h02;
  localparam logic [7:0] FAST_REG_B        = 8'h04;
  localparam logic [7:0] FAST_REG_C        = 8'h05;
  // parallel port output register, sits on the lower lane
  localparam logic [7:0] PORT_OUT_ADDR     = 8'h2E;
  localparam logic [7:0] PORT_OUT_RESET    = 8'h00;
  // spacing, in clock periods, that separates a pending write from a settled one
  localparam int         WRITE_GAP_MCLK    = 2;
  localparam logic [1:0] GAP_LIMIT         = 2'(WRITE_GAP_MCLK);
  localparam logic [1:0] GAP_SAT           = 2'h3;
  // read latencies in tenths of a clock period, longest times round down
  localparam int         LS_LAT_X10        = 15;
  localparam int         LS_PEND_LAT_X10   = 35;
  localparam logic [1:0] LAT_FAST          = 2'h1;
  localparam logic [1:0] LAT_SLOW          = 2'(LS_LAT_X10 / 10);
  localparam logic [1:0] LAT_SLOW_PEND     = 2'(LS_PEND_LAT_X10 / 10);
  // port pin update window after the end of the write, in clock periods
  localparam int         PORT_UPD_MIN_MCLK = 1;
  localparam int         PORT_UPD_MAX_MCLK = 2;

  typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT, ACK_LOW, ACK_PARK} ack_state_t;
endpackage

// ---- logic/host_bus_port.sv ----
// host bus port: multiplexed 16-bit and non-multiplexed asynchronous cycles,
// write holding stage, fast/slow register reads, acknowledge and port pins.
// assumes all host pins are already synchronous to clock_i.
// Operation
// - 16-bit mode: odd byte on upper lane, even byte on lower lane.
// - 16-bit mode: address bit zero is ignored in decoding.
// - upper strobe writes odd byte, lower strobe even byte; only strobed lanes.
// - 16-bit reads are always word reads returning both bytes.
// - read is unpending when over two clocks follow the last write end.
// - write is pending when two clocks or fewer follow the previous write end.
// - registers 02H, 04H, 05H answer fast, 02H in async mode only (16-bit word 02H is slow); all others are slow.
// - slow reads take about 1.5 clocks, or 3.5 with a write pending.
// - port pins update one to two clocks after the write ends.
// - async mode: acknowledge asserts promptly after chip select falls.
// - pending write: acknowledge waits two clocks past previous write end.
// - slow async reads have data valid by the acknowledge.
// - after chip select rises, acknowledge driven high briefly, then released.
// - async pending judged from previous write's chip select rising edge.
`timescale 1ns/100ps
module host_bus_port (
  input  wire logic                        clock_i,
  input  wire logic                        rst_i,
  input  wire logic                        mode_async_i,
  input  wire logic                        cs_n_i,
  input  wire logic                        rd_strobe_n_i,
  input  wire logic                        upper_byte_write_strobe_n_i,
  input  wire logic                        lower_byte_write_strobe_n_i,
  input  wire logic                        addr_latch_strobe_i,
  input  wire logic                        rw_n_i,
  input  wire logic [host_port_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [7:0]                  upper_addr_data_lane_i,
  input  wire logic [7:0]                  lower_addr_data_lane_i,
  output logic      [7:0]                  upper_addr_data_lane_o,
  output logic      [7:0]                  lower_addr_data_lane_o,
  output logic                             addr_data_lane_oe_o,
  output logic                             transfer_ack_n_o,
  output logic                             transfer_ack_oe_o,
  output logic      [7:0]                  port_pins_o
);
  import host_port_pkg::*;

  localparam int PORT_DLY = PORT_UPD_MAX_MCLK;

  logic [7:0]  regs_q [2**ADDR_W];
  logic        cs_n_q, rd_n_q, wh_n_q, wl_n_q, rw_n_q;
  logic [7:0]  addr_q, addr_d;
  logic [7:0]  hold_addr_q, hold_addr_d;
  logic [15:0] hold_data_q, hold_data_d;
  logic [1:0]  hold_be_q, hold_be_d;
  logic        hold_v_q, hold_v_d;
  logic [1:0]  gap_q, gap_d;
  logic [1:0]  rd_cnt_q, rd_cnt_d;
  logic        ack_rd_q, ack_rd_d, ack_n_q, ack_n_d, ack_oe_q, ack_oe_d;
  ack_state_t  ack_st_q, ack_st_d;
  logic [7:0]  up_q, up_d, lo_q, lo_d, port_q, port_d;
  logic        oe_q, oe_d;
  logic        cs_fall, cs_rise, wh_rise, wl_rise, wr_end, rd_start, acc_end;
  logic        pend_rd, pend_wr, fast, rd_load;
  logic [7:0]  cur_addr;

  function automatic logic is_fast(input logic [7:0] a);
    return (a == FAST_REG_A) || (a == FAST_REG_B) || (a == FAST_REG_C);
  endfunction

  // edge detection on the sampled host strobes
  always_comb begin
    cs_fall  = cs_n_q && !cs_n_i;
    cs_rise  = !cs_n_q && cs_n_i;
    wh_rise  = !wh_n_q && upper_byte_write_strobe_n_i && !cs_n_q;
    wl_rise  = !wl_n_q && lower_byte_write_strobe_n_i && !cs_n_q;
    // write ends on the strobe release, or on chip select release in async mode
    wr_end   = mode_async_i ? (cs_rise && !rw_n_q) : (wh_rise || wl_rise);
    rd_start = mode_async_i ? (cs_fall && rw_n_i)
                            : (rd_n_q && !rd_strobe_n_i && !cs_n_i);
    acc_end  = mode_async_i ? cs_rise : (!rd_n_q && rd_strobe_n_i);
    cur_addr = mode_async_i ? addr_i : addr_q;
    // a word read is fast only when both bytes are fast registers
    fast     = is_fast(cur_addr) && (mode_async_i || is_fast(cur_addr | 8'h01));
    pend_rd  = gap_q < GAP_LIMIT;  // gap lags the strobe by one edge
    pend_wr  = gap_q < GAP_LIMIT;
    rd_load  = rd_cnt_q == 2'h1;
  end

  // address latch, holding stage, write gap timer and port output
  always_comb begin
    addr_d      = addr_q;
    hold_addr_d = hold_addr_q;
    hold_data_d = hold_data_q;
    hold_be_d   = hold_be_q;
    hold_v_d    = 1'b0;
    gap_d       = (gap_q == GAP_SAT) ? gap_q : gap_q + 2'h1;
    port_d      = port_q;
    if (!mode_async_i && addr_latch_strobe_i) begin
      addr_d = {lower_addr_data_lane_i[7:1], 1'b0};
    end else if (mode_async_i && cs_fall) begin
      addr_d = addr_i;
    end
    if (wr_end) begin
      hold_v_d    = 1'b1;
      hold_addr_d = addr_q;
      gap_d       = 2'h0;
      if (mode_async_i) begin
        hold_data_d = {8'h00, lower_addr_data_lane_i};
        hold_be_d   = 2'b01;
      end else begin
        hold_data_d = {upper_addr_data_lane_i, lower_addr_data_lane_i};
        hold_be_d   = {wh_rise, wl_rise};
      end
    end
    // pins follow one edge after commit, so never sooner than one clock
    if (hold_v_q && hold_be_q[0] && hold_addr_q == PORT_OUT_ADDR) begin
      port_d = hold_data_q[7:0];
    end
    if (hold_v_q && hold_be_q[1] && (hold_addr_q | 8'h01) == PORT_OUT_ADDR) begin
      port_d = hold_data_q[15:8];
    end
  end

  // read latency counter and data lanes
  always_comb begin
    rd_cnt_d = (rd_cnt_q == 2'h0) ? rd_cnt_q : rd_cnt_q - 2'h1;
    up_d     = up_q;
    lo_d     = lo_q;
    oe_d     = oe_q;
    if (rd_start) begin
      // slow registers wait out a write that may still be committing
      rd_cnt_d = fast ? LAT_FAST : (pend_rd ? LAT_SLOW_PEND : LAT_SLOW);
    end else if (rd_load) begin
      oe_d = 1'b1;
      if (mode_async_i) begin
        lo_d = regs_q[addr_q];
        up_d = 8'h00;
      end else begin
        lo_d = regs_q[addr_q];
        up_d = regs_q[addr_q | 8'h01];
      end
    end
    if (acc_end) begin
      oe_d     = 1'b0;
      rd_cnt_d = 2'h0;
    end
  end

  // acknowledge handshake, used in the asynchronous mode only
  always_comb begin
    ack_st_d = ack_st_q;
    ack_rd_d = ack_rd_q;
    unique case (ack_st_q)
      ACK_IDLE: begin
        if (mode_async_i && cs_fall) begin
          ack_rd_d = rw_n_i;
          ack_st_d = (!rw_n_i && !pend_wr) ? ACK_LOW : ACK_WAIT;
        end
      end
      ACK_WAIT: begin
        if (cs_rise) begin
          ack_st_d = ACK_PARK;
        end else if (ack_rd_q ? rd_load : !pend_wr) begin
          ack_st_d = ACK_LOW;
        end
      end
      ACK_LOW: begin
        if (cs_rise) begin
          ack_st_d = ACK_PARK;
        end
      end
      ACK_PARK: begin
        ack_st_d = ACK_IDLE;
      end
    endcase
    // pins registered from the next state so they leave a flop with unchanged timing
    ack_n_d  = ack_st_d != ACK_LOW;
    ack_oe_d = (ack_st_d == ACK_LOW) || (ack_st_d == ACK_PARK);
  end

  // register stage; the register array itself is data and is not reset
  always_ff @(posedge clock_i) begin
    if (hold_v_q && hold_be_q[0]) begin
      regs_q[hold_addr_q] <= hold_data_q[7:0];
    end
    if (hold_v_q && hold_be_q[1]) begin
      regs_q[hold_addr_q | 8'h01] <= hold_data_q[15:8];
    end
    if (rst_i) begin
      cs_n_q      <= 1'b1;
      rd_n_q      <= 1'b1;
      wh_n_q      <= 1'b1;
      wl_n_q      <= 1'b1;
      rw_n_q      <= 1'b1;
      addr_q      <= 8'h00;
      hold_addr_q <= 8'h00;
      hold_data_q <= 16'h0000;
      hold_be_q   <= 2'b00;
      hold_v_q    <= 1'b0;
      gap_q       <= GAP_SAT;
      rd_cnt_q    <= 2'h0;
      ack_rd_q    <= 1'b0;
      ack_st_q    <= ACK_IDLE;
      ack_n_q     <= 1'b1;
      ack_oe_q    <= 1'b0;
      up_q        <= 8'h00;
      lo_q        <= 8'h00;
      oe_q        <= 1'b0;
      port_q      <= PORT_OUT_RESET;
    end else begin
      cs_n_q      <= cs_n_i;
      rd_n_q      <= rd_strobe_n_i;
      wh_n_q      <= upper_byte_write_strobe_n_i;
      wl_n_q      <= lower_byte_write_strobe_n_i;
      rw_n_q      <= rw_n_i;
      addr_q      <= addr_d;
      hold_addr_q <= hold_addr_d;
      hold_data_q <= hold_data_d;
      hold_be_q   <= hold_be_d;
      hold_v_q    <= hold_v_d;
      gap_q       <= gap_d;
      rd_cnt_q    <= rd_cnt_d;
      ack_rd_q    <= ack_rd_d;
      ack_st_q    <= ack_st_d;
      ack_n_q     <= ack_n_d;
      ack_oe_q    <= ack_oe_d;
      up_q        <= up_d;
      lo_q        <= lo_d;
      oe_q        <= oe_d;
      port_q      <= port_d;
    end
  end

  // outputs straight from flip-flops
  assign upper_addr_data_lane_o = up_q;
  assign lower_addr_data_lane_o = lo_q;
  assign addr_data_lane_oe_o    = oe_q;
  assign transfer_ack_n_o       = ack_n_q;
  assign transfer_ack_oe_o      = ack_oe_q;
  assign port_pins_o            = port_q;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_lsb_dropped;
    !mode_async_i && addr_latch_strobe_i |=> addr_q[0] == 1'b0;
  endproperty
  a_lsb_dropped: assert property (p_lsb_dropped) else $error("address bit zero kept");

  property p_lane_enables;
    !mode_async_i && wh_rise && !wl_rise |=> hold_v_q && hold_be_q == 2'b10;
  endproperty
  a_lane_enables: assert property (p_lane_enables) else $error("wrong byte lanes");

  property p_fast_read;
    rd_start && fast && !acc_end ##1 !acc_end |=> addr_data_lane_oe_o;
  endproperty
  a_fast_read: assert property (p_fast_read) else $error("fast read late");

  property p_slow_pend_read;
    rd_start && !fast && pend_rd |=> !rd_load [*2] ##1 (rd_load || rd_cnt_q == 2'h0);
  endproperty
  a_slow_pend_read: assert property (p_slow_pend_read) else $error("slow read latency");

  property p_port_update;
    wr_end && mode_async_i && addr_q == PORT_OUT_ADDR
      |=> $stable(port_pins_o) ##1 port_pins_o == $past(lower_addr_data_lane_i, PORT_DLY);
  endproperty
  a_port_update: assert property (p_port_update) else $error("port pins off window");

  property p_ack_prompt;
    ack_st_q == ACK_IDLE && mode_async_i && cs_fall && !rw_n_i && !pend_wr
      |=> !transfer_ack_n_o && transfer_ack_oe_o;
  endproperty
  a_ack_prompt: assert property (p_ack_prompt) else $error("write ack not prompt");

  property p_ack_wait_bound;
    ack_st_q == ACK_WAIT && !ack_rd_q |-> ##[0:2] ack_st_q != ACK_WAIT;
  endproperty
  a_ack_wait_bound: assert property (p_ack_wait_bound) else $error("write ack held too long");

  property p_ack_data;
    $fell(transfer_ack_n_o) && ack_rd_q |-> addr_data_lane_oe_o;
  endproperty
  a_ack_data: assert property (p_ack_data) else $error("ack before read data");

  property p_ack_park;
    ack_st_q == ACK_PARK |-> transfer_ack_n_o && transfer_ack_oe_o ##1 !transfer_ack_oe_o;
  endproperty
  a_ack_park: assert property (p_ack_park) else $error("ack not parked high");

  c_word_write: cover property (wh_rise && wl_rise);
  c_pend_write: cover property (ack_st_q == ACK_WAIT && !ack_rd_q ##1 ack_st_q == ACK_LOW);
  c_slow_read:  cover property (rd_start && !fast && !pend_rd);
endmodule

// ---- verification/host_master_model.sv ----
// bus master model for the host port: multiplexed and asynchronous cycles
// assumes the bench calls its tasks and shares clock_i with the port
`timescale 1ns/100ps
module host_master_model (
  input  wire logic       clock_i,
  input  wire logic       lane_oe_i,
  input  wire logic       ack_n_i,
  input  wire logic       ack_oe_i,
  input  wire logic [7:0] up_i,
  input  wire logic [7:0] lo_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wu_n_o,
  output logic            wl_n_o,
  output logic            ale_o,
  output logic            rw_n_o,
  output logic [7:0]      addr_o,
  output logic [7:0]      up_o,
  output logic [7:0]      lo_o
);
  // idle bus: strobes off, lanes carry a pattern rather than a stale value
  initial begin
    {cs_n_o, rd_n_o, wu_n_o, wl_n_o, ale_o, rw_n_o} = 6'h3D;
    addr_o = 8'h00;
    {up_o, lo_o} = 16'hA55A;
  end
  // address phase on the lower lane
  task automatic latch(input logic [7:0] a);
    @(posedge clock_i);
    ale_o <= 1'b1;
    lo_o  <= a;
    @(posedge clock_i);
    ale_o <= 1'b0;
  endtask
  // latch cycles keep write ends four clocks apart at least
  task automatic mux_write(input logic [7:0] a, input logic [15:0] d, input logic u,
                           input logic l);
    latch(a);
    cs_n_o       <= 1'b0;
    wu_n_o       <= !u;
    wl_n_o       <= !l;
    {up_o, lo_o} <= d;
    @(posedge clock_i);
    wu_n_o <= 1'b1;
    wl_n_o <= 1'b1;
    @(posedge clock_i);
    cs_n_o       <= 1'b1;
    {up_o, lo_o} <= ~d;
  endtask
  // pend reuses the last latched address so the read follows the write closely
  task automatic mux_read(input logic [7:0] a, input logic pend, output logic [15:0] d,
                          output int lat);
    if (!pend) latch(a);
    else @(posedge clock_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    lat = 0;
    while (lat < 12 && lane_oe_i !== 1'b1) begin
      @(posedge clock_i);
      lat++;
      #1;
    end
    d = {up_i, lo_i};
    @(posedge clock_i);
    rd_n_o <= 1'b1;
    cs_n_o <= 1'b1;
  endtask
  // quick keeps chip select high for the shortest legal gap, so the next write is pending;
  // a single high sample would land on the parked acknowledge cycle and be missed
  task automatic async_cycle(input logic rw, input logic [7:0] a, input logic [7:0] d,
                             input logic quick, output logic [7:0] q, output int lat,
                             output logic park);
    @(posedge clock_i);
    ale_o  <= 1'b1;
    cs_n_o <= 1'b0;
    rw_n_o <= rw;
    addr_o <= a;
    lo_o   <= d;
    lat = 0;
    while (lat < 12 && !(ack_oe_i === 1'b1 && ack_n_i === 1'b0)) begin
      @(posedge clock_i);
      lat++;
      #1;
    end
    q = lo_i;
    @(posedge clock_i);
    cs_n_o <= 1'b1;
    park = 1'b1;
    if (!quick) begin
      @(posedge clock_i);
      #1 park = (ack_oe_i === 1'b1) && (ack_n_i === 1'b1);
      @(posedge clock_i);
      lo_o <= ~d;
      #1 park = park && (ack_oe_i === 1'b0);
    end else begin
      @(posedge clock_i);
    end
  endtask
endmodule

// ---- verification/host_bus_port_tb.sv ----
// self-checking bench for the host bus port, mux mode then async mode
// assumes the register array keeps its contents across reset
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module host_bus_port_tb;
  import host_port_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        mode_async_i = 1'b0;
  logic        cs_n, rd_n, wu_n, wl_n, ale, rw_n, lane_oe, ack_n, ack_oe;
  logic [7:0]  addr, up_in, lo_in, up_out, lo_out, pins, a;
  logic [7:0]  mem [256];
  logic [31:0] seed = 32'h0000005F;
  int          err_total = 0;
  int          checked = 0;
  always #2.5 clock_i = ~clock_i;
  host_bus_port i_dut (.clock_i(clock_i), .rst_i(rst_i), .mode_async_i(mode_async_i),
    .cs_n_i(cs_n), .rd_strobe_n_i(rd_n), .upper_byte_write_strobe_n_i(wu_n),
    .lower_byte_write_strobe_n_i(wl_n), .addr_latch_strobe_i(ale), .rw_n_i(rw_n),
    .addr_i(addr), .upper_addr_data_lane_i(up_in), .lower_addr_data_lane_i(lo_in),
    .upper_addr_data_lane_o(up_out), .lower_addr_data_lane_o(lo_out),
    .addr_data_lane_oe_o(lane_oe), .transfer_ack_n_o(ack_n), .transfer_ack_oe_o(ack_oe),
    .port_pins_o(pins));
  host_master_model i_host (.clock_i(clock_i), .lane_oe_i(lane_oe), .ack_n_i(ack_n),
    .ack_oe_i(ack_oe), .up_i(up_out), .lo_i(lo_out), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wu_n_o(wu_n), .wl_n_o(wl_n), .ale_o(ale), .rw_n_o(rw_n), .addr_o(addr),
    .up_o(up_in), .lo_o(lo_in));
  // xorshift keeps the random stream repeatable
  function automatic logic [31:0] nxt(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // clocks from read start to lanes driven: fast words ignore pending writes
  function automatic int exp_lat(input logic fast, input logic pend);
    return (fast || !pend) ? 2 : 4;
  endfunction
  // verdict and end of run, also reached when a wait runs out
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // mirror follows the strobed lanes only
  task automatic wr(input logic [7:0] wa, input logic [15:0] d, input logic u, input logic l);
    if (u) mem[wa | 8'h01] = d[15:8];
    if (l) mem[wa & 8'hFE] = d[7:0];
    i_host.mux_write(wa, d, u, l);
  endtask
  task automatic rd(input logic [7:0] ra, input logic pend);
    logic [15:0] d;
    int          lat;
    i_host.mux_read(ra, pend, d, lat);
    if (lat >= 12) err_total++;
    if (lat >= 12) results();
    `CHK("word", {mem[ra | 8'h01], mem[ra & 8'hFE]}, d)
    `CHK("read latency", exp_lat((ra | 8'h01) == FAST_REG_C, pend), lat)
  endtask
  // async access with an accepted window for the acknowledge delay
  task automatic ac(input logic w, input logic [7:0] xa, input logic [7:0] d,
                    input logic quick, input int lo, input int hi);
    logic [7:0] q;
    int         lat;
    logic       park;
    i_host.async_cycle(!w, xa, d, quick, q, lat, park);
    if (lat >= 12) err_total++;
    if (lat >= 12) results();
    if (w) mem[xa] = d;
    else `CHK("async data", mem[xa], q)
    `CHK("ack in window", 1'b1, lat >= lo && lat <= hi)
    `CHK("ack park then release", 1'b1, park)
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    // corner cases: pending read, byte lanes, odd address, fast word 04H, slow word 02H
    wr(8'h40, 16'hA1B2, 1'b1, 1'b1);
    rd(8'h40, 1'b1);
    wr(8'h41, 16'h5C00, 1'b1, 1'b0);
    rd(8'h40, 1'b0);
    wr(8'h40, 16'h00D3, 1'b0, 1'b1);
    rd(8'h41, 1'b0);
    wr(8'h04, 16'h6E19, 1'b1, 1'b1);
    rd(8'h04, 1'b1);
    wr(8'h02, 16'h7B28, 1'b1, 1'b1);
    rd(8'h02, 1'b1);
    // port pins hold the old value one clock past the write end
    i_host.mux_write(PORT_OUT_ADDR, 16'h0077, 1'b0, 1'b1);
    #1 `CHK("pins early", PORT_OUT_RESET, pins)
    @(posedge clock_i);
    #1 `CHK("pins late", 8'h77, pins)
    // random word traffic in the slow register range
    repeat (8) begin
      seed = nxt(seed);
      a = 8'h10 + {2'h0, seed[5:1], 1'b0};
      if (a == PORT_OUT_ADDR) a = 8'h30;
      wr(a, seed[31:16], 1'b1, 1'b1);
      rd(a, seed[8]);
    end
    // mode changes only under reset
    @(posedge clock_i);
    rst_i        <= 1'b1;
    mode_async_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    ac(1'b1, 8'h60, 8'hC4, 1'b0, 1, 1);
    ac(1'b0, 8'h41, 8'h00, 1'b0, 2, 2);
    ac(1'b1, 8'h61, 8'h3F, 1'b1, 1, 1);
    ac(1'b1, 8'h62, 8'h9A, 1'b1, 2, 3);
    ac(1'b0, 8'h62, 8'h00, 1'b0, 4, 4);
    ac(1'b0, 8'h05, 8'h00, 1'b0, 2, 2);
    ac(1'b1, 8'h04, 8'hE7, 1'b1, 1, 1);
    ac(1'b0, 8'h04, 8'h00, 1'b0, 2, 2);
    // async write to the port register reaches the pins by the end of the park cycle
    ac(1'b1, PORT_OUT_ADDR, 8'h5D, 1'b0, 1, 1);
    `CHK("pins async", 8'h5D, pins)
    results();
  end
endmodule
